// ===== smcg_evt_reg.v
// Purpose: Sticky status, enable and interrupt for block events
// Assumes: Clear and enable writes come from the register port
// Notes:   A set in the clear cycle wins over the clear
`timescale 1ns/1ps
`default_nettype none
`include "smcg_map.vh"

module smcg_evt_reg #(
  parameter W = 3
) (
  input  wire         clk,       // System clock
  input  wire         sys_rst,   // Synchronous reset, active high
  input  wire [W-1:0] set,       // Event pulses
  input  wire         clr_we,    // Clear register write
  input  wire [W-1:0] clr_data,  // Ones clear status bits
  input  wire         en_we,     // Enable register write
  input  wire [W-1:0] en_data,   // New enable value
  output reg  [W-1:0] status,    // Sticky status bits
  output reg  [W-1:0] enable,    // Interrupt enable bits
  output wire         irq        // Level interrupt
);

  wire [W-1:0] clr_bits;

  assign clr_bits = clr_we ? clr_data : {W{1'b0}};

  // Sticky bits, set beats clear
  always @(posedge clk) begin
    if (sys_rst) begin
      status <= {W{1'b0}};
      enable <= {W{1'b0}};
    end else begin
      status <= (status & ~clr_bits) | set;
      if (en_we) begin
        enable <= en_data;
      end
    end
  end

  // Interrupt while an enabled bit is set
  assign irq = |(status & enable);

endmodule // smcg_evt_reg
`default_nettype wire

// ===== smcg_gate_chan.v
// Purpose: Clock enable and bus fault check for one gated unit
// Assumes: Mode selects are one-hot and come from the same clock
// Notes:   Enable and fault are both registered
`timescale 1ns/1ps
`default_nettype none
`include "smcg_map.vh"

module smcg_gate_chan (
  input  wire clk,        // System clock
  input  wire sys_rst,    // Synchronous reset, active high
  input  wire sel_run,    // Running operation selected
  input  wire sel_sleep,  // Sleep gating selected
  input  wire sel_deep,   // Deep-sleep gating selected
  input  wire run_en,     // Run-mode gate bit
  input  wire sleep_en,   // Sleep-mode gate bit
  input  wire deep_en,    // Deep-sleep gate bit
  input  wire access,     // Unit access strobe
  output reg  clk_en,     // Registered unit clock enable
  output reg  bus_fault,  // One-cycle bus fault pulse
  output wire fault_evt   // Fault event, same cycle as access
);

  reg next_clk_en;

  // Pick the gate bit of the active mode
  always @* begin
    next_clk_en = 1'b0;
    if (sel_sleep) begin
      next_clk_en = sleep_en;
    end else if (sel_deep) begin
      next_clk_en = deep_en;
    end else if (sel_run) begin
      next_clk_en = run_en;
    end
  end

  // Access to an unclocked unit faults
  assign fault_evt = access & ~clk_en; // RQ2

  // Enable changes only on a clock edge
  always @(posedge clk) begin
    if (sys_rst) begin
      clk_en    <= 1'b0; // RQ3
      bus_fault <= 1'b0;
    end else begin
      clk_en    <= next_clk_en; // RQ1 RQ12
      bus_fault <= fault_evt; // RQ2
    end
  end

endmodule // smcg_gate_chan
`default_nettype wire

// ===== smcg_map.vh
// Purpose: Constants of the sleep-mode clock gating control block
// Assumes: Included by every design file of the block
// Notes:   Definitions only
`ifndef SMCG_MAP_VH
`define SMCG_MAP_VH

// Register bus geometry
`define SMCG_ADDR_W       12
`define SMCG_DATA_W       32
`define SMCG_ZERO_WORD    32'h00000000

// Register byte offsets
`define SMCG_OFF_SLEEP    12'h110
`define SMCG_OFF_STAT     12'h1F0
`define SMCG_OFF_CLR      12'h1F4
`define SMCG_OFF_EN       12'h1F8

// Field positions in sleep_clock_gate_0
`define SMCG_ADC_BIT      16
`define SMCG_RATE_HI      9
`define SMCG_RATE_LO      8
`define SMCG_WDT_BIT      3

// Reset values
`define SMCG_RESET_PRINTED 32'h00000040
`define SMCG_WR_MASK       32'h00010308
`define SMCG_RESET_STORED  (`SMCG_RESET_PRINTED & `SMCG_WR_MASK)

// Converter sample rate codes
`define SMCG_RATE_125K    2'h0
`define SMCG_RATE_250K    2'h1
`define SMCG_RATE_500K    2'h2
`define SMCG_RATE_MAX     2'h2

// Event bits of the status, clear and enable registers
`define SMCG_EVT_W        3
`define SMCG_EVT_ADC      0
`define SMCG_EVT_WDT      1
`define SMCG_EVT_RATE     2
`define SMCG_EVT_ZERO     3'h0

`endif

// ===== smcg_sleep_gate.v
// Purpose: Sleep-mode clock gating control register and unit gates
// Assumes: Mode and access inputs come from logic on clk
// Notes:   Run and deep-sleep gate bits arrive as plain inputs
//
// Behaviour
// [RQ1] Set gate bit clocks the unit; clear bit leaves it unclocked.
// [RQ2] Access to an unclocked unit answers with a bus fault.
// [RQ3] All gate bits clear after reset, all units unclocked.
// [RQ4] This register governs unit clocks only while in Sleep.
// [RQ5] Sleep gating applies only when automatic gating select is set.
// [RQ6] Bit 16 is read/write and gates converter 0 in Sleep.
// [RQ7] Bit 3 is read/write and gates the watchdog in Sleep.
// [RQ8] Bits 9:8 select converter rate: 125K, 250K or 500K.
// [RQ9] Software keeps the rate at or below the supported maximum.
// [RQ10] Reserved bits read zero; software preserves them.
// [RQ11] Software enables each needed unit clock before use.
// [RQ12] Writes land next cycle; gate enables change at clock edges.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "smcg_map.vh"

module smcg_sleep_gate (
  input  wire                    clk,                  // System clock
  input  wire                    sys_rst,              // Sync reset, high
  // Register port
  input  wire [`SMCG_ADDR_W-1:0] reg_addr,             // Byte address
  input  wire [`SMCG_DATA_W-1:0] reg_wdata,            // Write data
  input  wire                    reg_wr,               // Write strobe
  input  wire                    reg_rd,               // Read strobe
  output reg  [`SMCG_DATA_W-1:0] reg_rdata,            // Read data
  // Power mode and run clock configuration
  input  wire                    cpu_sleep,            // Processor in Sleep
  input  wire                    cpu_deep_sleep,       // Processor deep sleep
  input  wire                    auto_clock_gating_select, // Use sleep regs
  input  wire                    run_gate_adc,         // Run-mode converter bit
  input  wire                    run_gate_wdt,         // Run-mode watchdog bit
  input  wire [1:0]              run_sample_rate,      // Run-mode rate field
  input  wire                    deep_gate_adc,        // Deep converter bit
  input  wire                    deep_gate_wdt,        // Deep watchdog bit
  // Unit access strobes
  input  wire                    adc_access,           // Converter access
  input  wire                    wdt_access,           // Watchdog access
  // Unit clock control
  output wire                    adc_clk_en,           // Converter clock on
  output wire                    watchdog_clock_gate,  // Watchdog clock on
  output reg  [1:0]              converter_sample_rate, // Applied rate
  output wire                    adc_bus_fault,        // Converter fault
  output wire                    wdt_bus_fault,        // Watchdog fault
  output reg  [1:0]              power_mode,           // Mode: 0 run 1 sl 2 dp
  output wire                    irq                   // Level interrupt
);

  // One-hot power mode states
  localparam [2:0] ST_RUN   = 3'b001;
  localparam [2:0] ST_SLEEP = 3'b010;
  localparam [2:0] ST_DEEP  = 3'b100;

  // Stored reset word, reserved bit of the printed value masked off
  localparam [`SMCG_DATA_W-1:0] RESET_WORD = `SMCG_RESET_STORED;

  // Mode codes shown on power_mode
  localparam [1:0] MODE_RUN   = 2'h0;
  localparam [1:0] MODE_SLEEP = 2'h1;
  localparam [1:0] MODE_DEEP  = 2'h2;

  // Stored fields of sleep_clock_gate_0
  reg                    sleep_gate_adc;
  reg                    sleep_gate_wdt;
  reg  [1:0]             sleep_rate;

  // Power mode state machine
  reg  [2:0]             mode;
  reg  [2:0]             next_mode;

  // Read path
  reg  [`SMCG_DATA_W-1:0] next_rdata;

  // Decoded accesses
  wire                   hit_sleep;
  wire                   hit_stat;
  wire                   hit_clr;
  wire                   hit_en;
  wire                   wr_sleep;
  wire                   wr_clr;
  wire                   wr_en;

  // Gating selects of the active mode
  wire                   sel_run;
  wire                   sel_sleep;
  wire                   sel_deep;

  // Event wiring
  wire                   adc_fault_evt;
  wire                   wdt_fault_evt;
  wire                   rate_bad_evt;
  wire [`SMCG_EVT_W-1:0] evt_set;
  wire [`SMCG_EVT_W-1:0] evt_status;
  wire [`SMCG_EVT_W-1:0] evt_enable;

  // Register image built from stored fields
  wire [`SMCG_DATA_W-1:0] sleep_image;
  wire [1:0]             wr_rate;

  // Address decode
  assign hit_sleep = (reg_addr == `SMCG_OFF_SLEEP);
  assign hit_stat  = (reg_addr == `SMCG_OFF_STAT);
  assign hit_clr   = (reg_addr == `SMCG_OFF_CLR);
  assign hit_en    = (reg_addr == `SMCG_OFF_EN);

  // Write qualifiers
  assign wr_sleep  = reg_wr & hit_sleep;
  assign wr_clr    = reg_wr & hit_clr;
  assign wr_en     = reg_wr & hit_en;

  // Rate field of the write word
  assign wr_rate   = reg_wdata[`SMCG_RATE_HI:`SMCG_RATE_LO];

  // Stored fields in place, reserved bits zero
  assign sleep_image = {
    {(`SMCG_DATA_W - 1 - `SMCG_ADC_BIT){1'b0}},
    sleep_gate_adc,                                          // RQ6
    {(`SMCG_ADC_BIT - 1 - `SMCG_RATE_HI){1'b0}},
    sleep_rate,                                              // RQ8
    {(`SMCG_RATE_LO - 1 - `SMCG_WDT_BIT){1'b0}},
    sleep_gate_wdt,                                          // RQ7
    {`SMCG_WDT_BIT{1'b0}}
  }; // RQ10

  // Sleep register fields, written only through the mask
  always @(posedge clk) begin
    if (sys_rst) begin
      sleep_gate_adc <= RESET_WORD[`SMCG_ADC_BIT]; // RQ3
      sleep_gate_wdt <= RESET_WORD[`SMCG_WDT_BIT]; // RQ3
      sleep_rate     <= `SMCG_RATE_125K; // RQ3
    end else if (wr_sleep) begin
      sleep_gate_adc <= reg_wdata[`SMCG_ADC_BIT]; // RQ6 RQ12
      sleep_gate_wdt <= reg_wdata[`SMCG_WDT_BIT]; // RQ7 RQ12
      sleep_rate     <= wr_rate; // RQ8 RQ12
    end
  end

  // Next power mode from processor state
  always @* begin
    next_mode = ST_RUN;
    case (mode)
      ST_RUN: begin
        if (cpu_deep_sleep) begin
          next_mode = ST_DEEP;
        end else if (cpu_sleep) begin
          next_mode = ST_SLEEP;
        end else begin
          next_mode = ST_RUN;
        end
      end
      ST_SLEEP: begin
        if (cpu_deep_sleep) begin
          next_mode = ST_DEEP;
        end else if (cpu_sleep) begin
          next_mode = ST_SLEEP;
        end else begin
          next_mode = ST_RUN;
        end
      end
      ST_DEEP: begin
        if (cpu_deep_sleep) begin
          next_mode = ST_DEEP;
        end else if (cpu_sleep) begin
          next_mode = ST_SLEEP;
        end else begin
          next_mode = ST_RUN;
        end
      end
      default: begin
        next_mode = ST_RUN;
      end
    endcase
  end

  // Mode register
  always @(posedge clk) begin
    if (sys_rst) begin
      mode <= ST_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  // Mode code for observers
  always @(posedge clk) begin
    if (sys_rst) begin
      power_mode <= MODE_RUN;
    end else begin
      case (next_mode)
        ST_SLEEP: power_mode <= MODE_SLEEP;
        ST_DEEP:  power_mode <= MODE_DEEP;
        default:  power_mode <= MODE_RUN;
      endcase
    end
  end

  // Sleep bits count only in Sleep with automatic gating selected
  assign sel_sleep = mode[1] & auto_clock_gating_select; // RQ4 RQ5
  assign sel_deep  = mode[2] & auto_clock_gating_select; // RQ4
  assign sel_run   = ~sel_sleep & ~sel_deep; // RQ4 RQ5

  // Converter clock gate
  smcg_gate_chan u_adc_gate (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .sel_run   (sel_run),
    .sel_sleep (sel_sleep),
    .sel_deep  (sel_deep),
    .run_en    (run_gate_adc),
    .sleep_en  (sleep_gate_adc),
    .deep_en   (deep_gate_adc),
    .access    (adc_access),
    .clk_en    (adc_clk_en),
    .bus_fault (adc_bus_fault),
    .fault_evt (adc_fault_evt)
  ); // RQ1 RQ6

  // Watchdog clock gate
  smcg_gate_chan u_wdt_gate (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .sel_run   (sel_run),
    .sel_sleep (sel_sleep),
    .sel_deep  (sel_deep),
    .run_en    (run_gate_wdt),
    .sleep_en  (sleep_gate_wdt),
    .deep_en   (deep_gate_wdt),
    .access    (wdt_access),
    .clk_en    (watchdog_clock_gate),
    .bus_fault (wdt_bus_fault),
    .fault_evt (wdt_fault_evt)
  ); // RQ1 RQ7

  // Applied converter rate follows the active register
  always @(posedge clk) begin
    if (sys_rst) begin
      converter_sample_rate <= `SMCG_RATE_125K;
    end else if (sel_sleep) begin
      converter_sample_rate <= sleep_rate; // RQ8 RQ4
    end else begin
      converter_sample_rate <= run_sample_rate;
    end
  end

  // Flag a rate write above the supported maximum
  assign rate_bad_evt = wr_sleep & (wr_rate > `SMCG_RATE_MAX); // RQ9

  // Event vector
  assign evt_set[`SMCG_EVT_ADC]  = adc_fault_evt;
  assign evt_set[`SMCG_EVT_WDT]  = wdt_fault_evt;
  assign evt_set[`SMCG_EVT_RATE] = rate_bad_evt;

  // Sticky status, clear and enable
  smcg_evt_reg #(
    .W (`SMCG_EVT_W)
  ) u_evt (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .set      (evt_set),
    .clr_we   (wr_clr),
    .clr_data (reg_wdata[`SMCG_EVT_W-1:0]),
    .en_we    (wr_en),
    .en_data  (reg_wdata[`SMCG_EVT_W-1:0]),
    .status   (evt_status),
    .enable   (evt_enable),
    .irq      (irq)
  );

  // Read multiplexer; clear register and holes read zero
  always @* begin
    next_rdata = `SMCG_ZERO_WORD;
    if (hit_sleep) begin
      next_rdata = sleep_image; // RQ10
    end else if (hit_stat) begin
      next_rdata = {{(`SMCG_DATA_W - `SMCG_EVT_W){1'b0}}, evt_status};
    end else if (hit_en) begin
      next_rdata = {{(`SMCG_DATA_W - `SMCG_EVT_W){1'b0}}, evt_enable};
    end else begin
      next_rdata = `SMCG_ZERO_WORD;
    end
  end

  // Read data stand one cycle after the strobe only
  always @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= `SMCG_ZERO_WORD;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= `SMCG_ZERO_WORD;
    end
  end

endmodule // smcg_sleep_gate
`default_nettype wire

// ===== smcg_sleep_gate_asserts.sv
// Purpose: Port-level checks of the sleep-mode clock gating block
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to the top module below
`timescale 1ns/1ps
`default_nettype none
`include "smcg_map.vh"

module smcg_sleep_gate_asserts (
  input wire logic        clk,                      // System clock
  input wire logic        sys_rst,                  // Sync reset
  input wire logic [11:0] reg_addr,                 // Byte address
  input wire logic [31:0] reg_wdata,                // Write data
  input wire logic        reg_wr,                   // Write strobe
  input wire logic        reg_rd,                   // Read strobe
  input wire logic [31:0] reg_rdata,                // Read data
  input wire logic        cpu_sleep,                // Sleep
  input wire logic        cpu_deep_sleep,           // Deep sleep
  input wire logic        auto_clock_gating_select, // Use sleep regs
  input wire logic        run_gate_adc,             // Run converter bit
  input wire logic        run_gate_wdt,             // Run watchdog bit
  input wire logic [1:0]  run_sample_rate,          // Run rate
  input wire logic        deep_gate_adc,            // Deep converter bit
  input wire logic        deep_gate_wdt,            // Deep watchdog bit
  input wire logic        adc_access,               // Converter access
  input wire logic        wdt_access,               // Watchdog access
  input wire logic        adc_clk_en,               // Converter clock on
  input wire logic        watchdog_clock_gate,      // Watchdog clock on
  input wire logic [1:0]  converter_sample_rate,    // Applied rate
  input wire logic        adc_bus_fault,            // Converter fault
  input wire logic        wdt_bus_fault,            // Watchdog fault
  input wire logic [1:0]  power_mode                // Mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [31:0] sl_q;   // Mirror of stored sleep register
  logic        sel_dp; // Deep gating in force
  logic        sel_sl; // Sleep gating in force
  logic        adc_x;  // Expected converter enable
  logic        wdt_x;  // Expected watchdog enable
  logic [1:0]  rate_x; // Expected applied rate

  // Sleep register mirror from bus writes
  always_ff @(posedge clk) begin
    if (sys_rst) sl_q <= `SMCG_ZERO_WORD;
    else if (reg_wr && reg_addr == `SMCG_OFF_SLEEP) sl_q <= reg_wdata & `SMCG_WR_MASK;
  end

  // Selected gate bits for the current mode
  always_comb begin
    sel_dp = auto_clock_gating_select && power_mode == 2'h2;
    sel_sl = auto_clock_gating_select && power_mode == 2'h1;
    adc_x  = sel_dp ? deep_gate_adc : (sel_sl ? sl_q[16] : run_gate_adc);
    wdt_x  = sel_dp ? deep_gate_wdt : (sel_sl ? sl_q[3] : run_gate_wdt);
    rate_x = sel_sl ? sl_q[9:8] : run_sample_rate;
  end

  sequence s_calm;
    $stable({auto_clock_gating_select, power_mode, run_gate_adc, run_gate_wdt,
             run_sample_rate, deep_gate_adc, deep_gate_wdt});
  endsequence
  sequence s_rd_sleep;
    reg_rd && reg_addr == `SMCG_OFF_SLEEP;
  endsequence
  sequence s_wr_sleep;
    reg_wr && reg_addr == `SMCG_OFF_SLEEP;
  endsequence

  a_mode_follow: assert property (
    1'b1 |=> power_mode == ($past(cpu_deep_sleep) ? 2'h2 : {1'b0, $past(cpu_sleep)}))
    else $error("power mode does not follow the sleep inputs");
  a_adc_gate: assert property (
    s_calm |=> adc_clk_en == $past(adc_x))
    else $error("converter enable differs from selected bit");
  a_wdt_gate: assert property (
    s_calm |=> watchdog_clock_gate == $past(wdt_x))
    else $error("watchdog enable differs from selected bit");
  a_rate_apply: assert property (
    s_calm |=> converter_sample_rate == $past(rate_x))
    else $error("applied rate differs from selected field");
  a_fault_pulse: assert property (
    1'b1 |=> {adc_bus_fault, wdt_bus_fault} ==
      $past({adc_access && !adc_clk_en, wdt_access && !watchdog_clock_gate}))
    else $error("bus fault does not match access to unclocked unit");
  a_read_back: assert property (
    s_rd_sleep |=> reg_rdata == $past(sl_q))
    else $error("sleep register read data wrong");
  a_write_lands: assert property (
    s_wr_sleep ##1 s_rd_sleep |=> reg_rdata == ($past(reg_wdata, 2) & `SMCG_WR_MASK))
    else $error("write not visible in next read");
  a_idle_zero: assert property (
    !(reg_rd && (reg_addr == `SMCG_OFF_SLEEP || reg_addr == `SMCG_OFF_STAT ||
      reg_addr == `SMCG_OFF_EN)) |=> reg_rdata == `SMCG_ZERO_WORD)
    else $error("read data not zero");
  a_reset_quiet: assert property (
    disable iff (1'b0) sys_rst |=> !adc_clk_en && !watchdog_clock_gate && power_mode == 2'h0)
    else $error("units clocked during reset");
endmodule // smcg_sleep_gate_asserts

bind smcg_sleep_gate smcg_sleep_gate_asserts u_chk (.clk, .sys_rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .cpu_sleep, .cpu_deep_sleep, .auto_clock_gating_select,
  .run_gate_adc, .run_gate_wdt, .run_sample_rate, .deep_gate_adc, .deep_gate_wdt,
  .adc_access, .wdt_access, .adc_clk_en, .watchdog_clock_gate, .converter_sample_rate,
  .adc_bus_fault, .wdt_bus_fault, .power_mode);

`default_nettype wire

// ===== smcg_sleep_gate_tb_top.sv
// Purpose: Self-checking bench of the sleep-mode clock gating block
// Assumes: Read data stands one cycle after the read strobe
// Notes:   Bench model mirrors register, status and gate selection
`timescale 1ns/1ps
`default_nettype none
`include "smcg_map.vh"

`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, (g), (e)); end end

module smcg_sleep_gate_tb_top;
  logic        clk, sys_rst, reg_wr, reg_rd, cpu_sleep, cpu_deep_sleep;
  logic        auto_clock_gating_select, run_gate_adc, run_gate_wdt, irq;
  logic        deep_gate_adc, deep_gate_wdt, adc_access, wdt_access;
  logic        adc_clk_en, watchdog_clock_gate, adc_bus_fault, wdt_bus_fault;
  logic [1:0]  run_sample_rate, converter_sample_rate, power_mode;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, m_sl, got;
  logic [2:0]  m_st, m_en;
  int          error_cnt, n_tests, cyc;

  smcg_sleep_gate DUT (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cpu_sleep, .cpu_deep_sleep, .auto_clock_gating_select, .run_gate_adc, .run_gate_wdt,
    .run_sample_rate, .deep_gate_adc, .deep_gate_wdt, .adc_access, .wdt_access, .adc_clk_en,
    .watchdog_clock_gate, .converter_sample_rate, .adc_bus_fault, .wdt_bus_fault,
    .power_mode, .irq);

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic stop_test();
    if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Register write, model follows
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a == `SMCG_OFF_SLEEP) m_sl = d & `SMCG_WR_MASK;
    if (a == `SMCG_OFF_SLEEP && d[9:8] == 2'h3) m_st[2] = 1'b1;
    if (a == `SMCG_OFF_CLR) m_st = m_st & ~d[2:0];
    if (a == `SMCG_OFF_EN) m_en = d[2:0];
  endtask

  // Register read, data captured in the cycle after
  task automatic rd(input logic [11:0] a);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
    @(posedge clk);
  endtask

  // Expected {converter, watchdog, rate} for present inputs
  function automatic logic [3:0] gates();
    if (cpu_deep_sleep && auto_clock_gating_select)
      return {deep_gate_adc, deep_gate_wdt, run_sample_rate};
    if (cpu_sleep && auto_clock_gating_select) return {m_sl[16], m_sl[3], m_sl[9:8]};
    return {run_gate_adc, run_gate_wdt, run_sample_rate};
  endfunction

  // Apply a mode, let it settle, compare unit controls
  task automatic mode(input logic [2:0] m);
    {cpu_deep_sleep, cpu_sleep, auto_clock_gating_select} <= m;
    repeat (3) @(posedge clk);
    #1 `CHK({adc_clk_en, watchdog_clock_gate, converter_sample_rate}, gates())
    `CHK(power_mode, cpu_deep_sleep ? 2'h2 : {1'b0, cpu_sleep})
    @(posedge clk);
  endtask

  // One access pulse per unit, fault and interrupt compared
  task automatic acc(input logic a, input logic w);
    logic [3:0] g;
    g = gates();
    adc_access <= a;
    wdt_access <= w;
    @(posedge clk);
    adc_access <= 1'b0;
    wdt_access <= 1'b0;
    m_st[1:0] = m_st[1:0] | {w & ~g[2], a & ~g[3]};
    #1 `CHK({adc_bus_fault, wdt_bus_fault}, {a & ~g[3], w & ~g[2]})
    `CHK(irq, |(m_st & m_en))
    @(posedge clk);
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      stop_test();
    end
  end

  initial begin
    {reg_wr, reg_rd, cpu_sleep, cpu_deep_sleep, auto_clock_gating_select} = 5'h00;
    {run_gate_adc, run_gate_wdt, deep_gate_adc, deep_gate_wdt} = 4'h0;
    {adc_access, wdt_access, run_sample_rate, reg_addr, reg_wdata} = 48'h0;
    {m_sl, m_st, m_en, error_cnt, n_tests} = '0;
    sys_rst = 1'b1;
    void'($urandom(32'h7C4B));
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`SMCG_OFF_SLEEP);
    `CHK(got, 32'h00000000)
    `CHK({adc_clk_en, watchdog_clock_gate, power_mode}, 4'h0)
    // Every rate code, random other bits, read straight after write
    for (int r = 0; r < 4; r++) begin
      wr(`SMCG_OFF_SLEEP, ($urandom & 32'hFFFFFCFF) | (32'(r) << 8));
      rd(`SMCG_OFF_SLEEP);
      `CHK(got, m_sl)
    end
    rd(`SMCG_OFF_STAT);
    `CHK(got, {29'h0, m_st})
    wr(`SMCG_OFF_CLR, 32'h00000007);
    @(posedge clk);
    wr(`SMCG_OFF_STAT, 32'hFFFFFFFF);
    rd(`SMCG_OFF_STAT);
    `CHK(got, {29'h0, m_st})
    rd(12'h120);
    `CHK(got, 32'h00000000)
    wr(`SMCG_OFF_EN, 32'h00000003);
    rd(`SMCG_OFF_EN);
    `CHK(got, {29'h0, m_en})
    // All mode combinations with random gate bits
    for (int i = 0; i < 8; i++) begin
      wr(`SMCG_OFF_SLEEP, $urandom & 32'hFFFFFDFF);
      {run_gate_adc, run_gate_wdt, deep_gate_adc, deep_gate_wdt} <= 4'($urandom);
      run_sample_rate <= 2'($urandom_range(2));
      mode(3'(i));
    end
    // Converter gated off in sleep, watchdog clocked
    wr(`SMCG_OFF_SLEEP, 32'h00000008);
    mode(3'h3);
    acc(1'b1, 1'b1);
    wr(`SMCG_OFF_CLR, 32'h00000001);
    #1 `CHK(irq, |(m_st & m_en))
    @(posedge clk);
    // Watchdog gated off, interrupt masked
    wr(`SMCG_OFF_SLEEP, 32'h00010000);
    mode(3'h3);
    wr(`SMCG_OFF_EN, 32'h00000000);
    acc(1'b1, 1'b1);
    rd(`SMCG_OFF_STAT);
    `CHK(got, {29'h0, m_st})
    // Reset in mid-run clears a written register and sticky status
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    {m_sl, m_st, m_en} = '0;
    rd(`SMCG_OFF_SLEEP);
    `CHK(got, m_sl)
    rd(`SMCG_OFF_STAT);
    `CHK(got, {29'h0, m_st})
    stop_test();
  end
endmodule // smcg_sleep_gate_tb_top

`default_nettype wire
